// ### lcs_pack_model.sv
// Pack, thermistor and source model facing the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module lcs_pack_model
  import lcs_pkg::*;
(
  input  wire logic       clock_i,   // System clock
  input  wire logic       reset_i,   // Asynchronous reset, high
  input  wire lcs_ctl_s   ctl_i,     // Regulation controls from the sequencer
  input  wire logic       supply_i,  // Source plugged and healthy
  input  wire logic [1:0] temp_i,    // 0 cold, 1 in range, 2 no thermistor, 3 hot
  input  wire logic       drain_i,   // Load pulls the pack down 300 mV
  input  wire logic       hold_i,    // Freeze voltage and current
  output lcs_cmp_s        cmp_o      // Comparator flags to the sequencer
);
  int mv_q;   // Pack voltage in mV
  int pct_q;  // Charge current in percent of C
  int tgt;    // Regulation target in mV
  assign tgt = ctl_i.vsel_4v2 ? 4200 : 4100;
  // Pack charges slowly in pre-qualification, faster in CC, tapers in CV
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mv_q  <= 2900;
      pct_q <= 100;
    end else if (drain_i) begin
      mv_q <= mv_q - 300;
    end else if (hold_i) begin
      mv_q <= mv_q;
    end else if (ctl_i.charge_on && ctl_i.cv_mode) begin
      pct_q <= (pct_q > 0) ? pct_q - 1 : 0;
    end else if (ctl_i.charge_on) begin
      mv_q  <= (mv_q + (ctl_i.prequal ? 1 : 5) > tgt) ? tgt : mv_q + (ctl_i.prequal ? 1 : 5);
      pct_q <= 100;
    end
  end
  // Comparators see the modelled analog levels
  always_comb begin
    cmp_o                  = '0;
    cmp_o.supply_above_uv  = supply_i;
    cmp_o.supply_below_ov  = supply_i;
    cmp_o.adaptor_ok       = supply_i;
    cmp_o.batt_above_3v0   = mv_q > 3000;
    cmp_o.batt_at_reg      = mv_q >= tgt;
    cmp_o.batt_below_rechg = mv_q <= tgt - 200;
    cmp_o.ts_ge_2v7        = temp_i == 2'h2;
    cmp_o.ts_ge_2v427      = temp_i[1];
    cmp_o.ts_gt_1v39       = temp_i != 2'h0;
    cmp_o.eoc_010          = pct_q < 10;
    cmp_o.eoc_015          = pct_q < 15;
    cmp_o.eoc_020          = pct_q < 20;
  end
endmodule
`default_nettype wire

// ### lcs_pkg.sv
// Package: constants, modes and carriers of the charge sequencer
package lcs_pkg;
  // Wishbone register byte offsets
  localparam logic [7:0] LCS_REG_CHG1 = 8'h00;  // Regulation voltage, adaptor current
  localparam logic [7:0] LCS_REG_CHG2 = 8'h04;  // Status bits, end-of-charge select
  localparam logic [7:0] LCS_REG_CHG3 = 8'h08;  // USB charge current code
  localparam logic [7:0] LCS_REG_STAT = 8'h0c;  // Phase and input flags
  // Field positions
  localparam int LCS_VSEL_BIT   = 4;  // Regulation voltage select, 1 = 4.2 V
  localparam int LCS_EOCSEL_LSB = 1;  // End-of-charge select field low bit
  localparam int LCS_CHG_BIT    = 3;  // Charging status bit
  localparam int LCS_EOC_BIT    = 4;  // End-of-charge status bit
  // Reset values
  localparam logic [3:0] LCS_RST_AC_CODE  = 4'h8;  // 500 mA
  localparam logic [3:0] LCS_RST_USB_CODE = 4'h8;  // 500 mA
  localparam logic       LCS_RST_VSEL     = 1'b0;  // 4.1 V
  localparam logic [1:0] LCS_RST_EOCSEL   = 2'h1;  // 0.1C
  // Current codes
  localparam logic [3:0] LCS_CODE_100MA   = 4'h0;  // 100 mA, code 0
  localparam logic [3:0] LCS_CODE_MAX     = 4'hd;  // 750 mA, highest code
  localparam int         LCS_BASE_MA      = 100;   // Current of code 0
  localparam int         LCS_STEP_MA      = 50;    // Current per code step
  // Safety timer
  localparam int         LCS_CLK_MHZ      = 100;   // Clock rate in MHz
  localparam int         LCS_TIMEOUT_TENTH_HR = 56; // 5.6 hours, in tenths
  localparam longint     LCS_TIMEOUT_CYC  =
    longint'(LCS_TIMEOUT_TENTH_HR) * 360 * 1000000 * LCS_CLK_MHZ;
  localparam int         LCS_PRESCALE     = 1000000; // Cycles per timer tick
  localparam int         LCS_TIMEOUT_TICKS = int'(LCS_TIMEOUT_CYC / LCS_PRESCALE);

  // Charge phases
  typedef enum logic [2:0] {
    LCS_OFF, LCS_PREQUAL, LCS_CC, LCS_CV, LCS_MAINT, LCS_FAULT, LCS_LDO, LCS_DISABLED
  } lcs_phase_e;

  // Thermistor classes
  typedef enum logic [1:0] {LCS_T_OFF, LCS_T_CHARGE, LCS_T_LDO} lcs_temp_e;

  // Comparator flags from the analog front end
  typedef struct packed {
    logic supply_above_uv;   // Supply above under-voltage threshold
    logic supply_below_ov;   // Supply below over-voltage threshold
    logic adaptor_ok;        // Adaptor-good indication
    logic batt_above_3v0;    // Pack above pre-qualification threshold
    logic batt_at_reg;       // Pack reached regulation voltage
    logic batt_below_rechg;  // Pack 200 mV below termination
    logic ts_ge_2v7;         // Sense at or above LDO threshold
    logic ts_ge_2v427;       // Sense at or above upper charge bound
    logic ts_gt_1v39;        // Sense above lower charge bound
    logic eoc_010;           // Current below 0.1C
    logic eoc_015;           // Current below 0.15C
    logic eoc_020;           // Current below 0.2C
  } lcs_cmp_s;

  // Controls to the analog regulation loop
  typedef struct packed {
    logic       charge_on;   // Pass device enabled for charging
    logic       prequal;     // Limited pre-qualification current
    logic       cv_mode;     // Constant-voltage regulation
    logic       ldo_mode;    // LDO regulation at battery voltage
    logic       vsel_4v2;    // Regulation target 4.2 V
    logic [3:0] charge_current; // Current code, 100 mA plus 50 mA steps
  } lcs_ctl_s;
endpackage

// ### lcs_top.sv
// Lithium-ion charge sequencer with Wishbone settings registers
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Start pre-qualification only with supply good
// - Limited current until pack exceeds 3.0V
// - Adaptor current defaults 500mA, register programmable
// - USB: select pin high 100mA, else programmable
// - Adaptor mode ignores current-select pin
// - Timer from CC; expiry faults, both indicators
// - CC to CV at regulation voltage
// - CV current below threshold enters maintenance
// - End-of-charge threshold 0.1C, 0.15C, 0.2C
// - Maintenance restarts charge on 200mV drop
// - Adaptor current 100 to 750mA, 50mA steps
// - Indicators encoded from phase
// - Classify sense voltage: LDO, charge, off
// - Temperature out stops; return restarts, timer reset
// - Floating sense selects LDO at battery voltage
// - Enable pin gates charger and LDO
// - Defaults after power-up until reprogrammed
// - Current code 0 is 100mA, 0xD 750mA
// - Status bits read-only, settings read-write
module lcs_top
  import lcs_pkg::*;
#(
  parameter int PRESCALE      = LCS_PRESCALE,      // Cycles per timer tick
  parameter int TIMEOUT_TICKS = LCS_TIMEOUT_TICKS  // Ticks to safety timeout
) (
  input  wire logic        clock_i,                 // System clock
  input  wire logic        reset_i,                 // Asynchronous reset, high
  input  wire logic        wb_cyc_i,                // Wishbone cycle
  input  wire logic        wb_stb_i,                // Wishbone strobe
  input  wire logic        wb_we_i,                 // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,                // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,                // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,                // Wishbone write data
  output logic      [31:0] wb_dat_o,                // Wishbone read data
  output logic             wb_ack_o,                // Wishbone acknowledge
  input  wire lcs_cmp_s    cmp_i,                   // Asynchronous comparator flags
  input  wire logic        enable_pin_i,            // Charger enable pin
  input  wire logic        source_mode_pin_i,       // High adaptor, low USB
  input  wire logic        current_select_pin_i,    // USB low-power select
  output lcs_ctl_s         ctl_o,                   // Regulation loop controls
  output logic             charging_indicator_o,    // Charging indicator on
  output logic             eoc_indicator_o          // End-of-charge indicator on
);

  // Synchronizer stages for comparator flags and pins
  localparam int SYNC_W = $bits(lcs_cmp_s) + 3;
  logic [SYNC_W-1:0] sync1_q;                       // First stage, read by second only
  logic [SYNC_W-1:0] sync2_q;                       // Second stage, used by logic
  lcs_cmp_s          cmp;                           // Synchronized comparator flags
  logic              en_s;                          // Synchronized enable
  logic              adaptor_s;                     // Synchronized source mode
  logic              current_select_pin_s;                        // Synchronized current select

  // Two flops on every asynchronous input
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {cmp_i, enable_pin_i, source_mode_pin_i, current_select_pin_i};
      sync2_q <= sync1_q;
    end
  end

  // Unpack synchronized flags
  always_comb begin
    cmp       = lcs_cmp_s'(sync2_q[SYNC_W-1:3]);
    en_s      = sync2_q[2];
    adaptor_s = sync2_q[1];
    current_select_pin_s    = sync2_q[0];
  end

  // Settings registers
  logic [3:0] ac_code_q, ac_code_d;                 // Adaptor current code
  logic [3:0] usb_code_q, usb_code_d;               // USB current code
  logic       vsel_q, vsel_d;                       // Regulation voltage select
  logic [1:0] eocsel_q, eocsel_d;                   // End-of-charge select
  logic       ack_q, ack_d;                         // Bus acknowledge
  logic [31:0] rdat_q, rdat_d;                      // Read data

  // Sequencer state
  lcs_phase_e phase_q, phase_d;                     // Charge phase
  logic       maint_seen_q, maint_seen_d;           // Maintenance was reached
  logic       temp_fault_q, temp_fault_d;           // Fault phase came from temperature
  logic [31:0] pre_q, pre_d;                        // Timer prescaler
  logic [31:0] tick_q, tick_d;                      // Timer tick count
  lcs_temp_e  temp;                                 // Thermistor class
  logic       supply_ok;                            // Supply qualified
  logic       eoc_hit;                              // Current below threshold
  logic       timeout;                              // Safety timer expired

  // Clamp a current code to the highest legal step
  function automatic logic [3:0] lcs_clamp(input logic [3:0] c);
    lcs_clamp = (c > LCS_CODE_MAX) ? LCS_CODE_MAX : c;
  endfunction

  // Bus access decode and register updates
  always_comb begin
    ac_code_d  = ac_code_q;
    usb_code_d = usb_code_q;
    vsel_d     = vsel_q;
    eocsel_d   = eocsel_q;
    rdat_d     = rdat_q;
    ack_d      = 1'b0;
    // Take one request per bus cycle; a standing ack blocks a second take
    if (wb_cyc_i && wb_stb_i && !ack_q) begin
      ack_d  = 1'b1;
      rdat_d = 32'h0;
      if (wb_adr_i == LCS_REG_CHG1) begin
        rdat_d[4:0] = {vsel_q, ac_code_q};
        if (wb_we_i && wb_sel_i[0]) begin
          ac_code_d = lcs_clamp(wb_dat_i[3:0]);
          vsel_d    = wb_dat_i[LCS_VSEL_BIT];
        end
      end else if (wb_adr_i == LCS_REG_CHG2) begin
        rdat_d[LCS_EOC_BIT]            = eoc_indicator_o;
        rdat_d[LCS_CHG_BIT]            = charging_indicator_o;
        rdat_d[LCS_EOCSEL_LSB +: 2]    = eocsel_q;
        if (wb_we_i && wb_sel_i[0]) begin
          // Status bits ignore writes; only the select is stored
          eocsel_d = wb_dat_i[LCS_EOCSEL_LSB +: 2];
        end
      end else if (wb_adr_i == LCS_REG_CHG3) begin
        rdat_d[3:0] = usb_code_q;
        if (wb_we_i && wb_sel_i[0]) begin
          usb_code_d = lcs_clamp(wb_dat_i[3:0]);
        end
      end else if (wb_adr_i == LCS_REG_STAT) begin
        rdat_d[2:0] = phase_q;
        rdat_d[4:3] = temp;
        rdat_d[5]   = adaptor_s;
        rdat_d[6]   = en_s;
      end else begin
        rdat_d = 32'h0;  // Unmapped reads zero, writes dropped
      end
    end
  end

  // Register the bus-side state
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ac_code_q  <= LCS_RST_AC_CODE;
      usb_code_q <= LCS_RST_USB_CODE;
      vsel_q     <= LCS_RST_VSEL;
      eocsel_q   <= LCS_RST_EOCSEL;
      ack_q      <= 1'b0;
      rdat_q     <= 32'h0;
    end else begin
      ac_code_q  <= ac_code_d;
      usb_code_q <= usb_code_d;
      vsel_q     <= vsel_d;
      eocsel_q   <= eocsel_d;
      ack_q      <= ack_d;
      rdat_q     <= rdat_d;
    end
  end

  // Classification, qualification and threshold pick
  always_comb begin
    if (cmp.ts_ge_2v7) begin
      temp = LCS_T_LDO;
    end else if (cmp.ts_gt_1v39 && !cmp.ts_ge_2v427) begin
      temp = LCS_T_CHARGE;
    end else begin
      temp = LCS_T_OFF;
    end
    supply_ok = cmp.supply_above_uv && cmp.supply_below_ov && cmp.adaptor_ok;
    case (eocsel_q)
      2'h2:    eoc_hit = cmp.eoc_015;
      2'h3:    eoc_hit = cmp.eoc_020;
      default: eoc_hit = cmp.eoc_010;
    endcase
    timeout = (tick_q >= 32'(TIMEOUT_TICKS));
  end

  // Phase sequencer
  // Priority runs supply, then enable, then sense class, then the charge flow
  always_comb begin
    phase_d      = phase_q;
    maint_seen_d = maint_seen_q;
    temp_fault_d = temp_fault_q;
    if (!supply_ok) begin
      // Source gone: everything starts over, history included
      phase_d      = LCS_OFF;
      maint_seen_d = 1'b0;
    end else if (!en_s) begin
      // Host holds the charger off
      phase_d = LCS_DISABLED;
    end else if (temp == LCS_T_LDO) begin
      // No thermistor: regulate as a plain LDO
      phase_d = LCS_LDO;
    end else if (temp == LCS_T_OFF) begin
      // Out of range: stop, restart from the start on recovery
      phase_d = (phase_q == LCS_FAULT) ? LCS_FAULT : LCS_OFF;
    end else begin
      case (phase_q)
        LCS_OFF, LCS_DISABLED, LCS_LDO: begin
          // Every start goes through pre-qualification
          phase_d = LCS_PREQUAL;
        end
        LCS_PREQUAL: begin
          // Trickle until the pack is past the deep-discharge point
          if (cmp.batt_above_3v0) phase_d = LCS_CC;
        end
        LCS_CC: begin
          if (timeout) begin
            phase_d = LCS_FAULT;
          end else if (cmp.batt_at_reg) begin
            phase_d = LCS_CV;
          end
        end
        LCS_CV: begin
          // Taper current decides the end of charge
          if (eoc_hit) phase_d = LCS_MAINT;
        end
        LCS_MAINT: begin
          maint_seen_d = 1'b1;
          if (cmp.batt_below_rechg) phase_d = LCS_PREQUAL;
        end
        LCS_FAULT: phase_d = LCS_FAULT;  // Timer fault holds until source or enable drops or the sense class turns to LDO
        default:   phase_d = LCS_OFF;
      endcase
    end
    // A temperature fault latches the fault phase while charging
    if (supply_ok && en_s && temp == LCS_T_OFF &&
        (phase_q == LCS_PREQUAL || phase_q == LCS_CC || phase_q == LCS_CV)) begin
      phase_d      = LCS_FAULT;
      temp_fault_d = 1'b1;
    end
    // Only a temperature fault clears itself; a timer fault stays put
    if (phase_q == LCS_FAULT && temp_fault_q &&
        temp == LCS_T_CHARGE && supply_ok && en_s) begin
      phase_d = LCS_PREQUAL;
    end
    // The cause is only kept while the fault phase lasts
    if (phase_d != LCS_FAULT) begin
      temp_fault_d = 1'b0;
    end
  end

  // Safety timer, cleared outside constant current
  always_comb begin
    pre_d  = pre_q;
    tick_d = tick_q;
    if (phase_q != LCS_CC) begin
      pre_d  = 32'h0;
      tick_d = 32'h0;
    end else if (!timeout) begin
      // Count stops at expiry so the fault cannot wrap away
      if (pre_q >= 32'(PRESCALE - 1)) begin
        // Prescaler wraps into one tick of the safety timer
        pre_d  = 32'h0;
        tick_d = tick_q + 32'h1;
      end else begin
        pre_d = pre_q + 32'h1;
      end
    end
  end

  // Register sequencer and timer
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      phase_q      <= LCS_OFF;
      maint_seen_q <= 1'b0;
      temp_fault_q <= 1'b0;
      pre_q        <= 32'h0;
      tick_q       <= 32'h0;
    end else begin
      phase_q      <= phase_d;
      maint_seen_q <= maint_seen_d;
      temp_fault_q <= temp_fault_d;
      pre_q        <= pre_d;
      tick_q       <= tick_d;
    end
  end

  // Output controls and indicators, next values
  lcs_ctl_s ctl_d;                                  // Next regulation controls
  logic     chg_ind_d, eoc_ind_d;                   // Next indicator levels
  always_comb begin
    ctl_d          = '0;
    ctl_d.vsel_4v2 = vsel_q;
    // Adaptor mode ignores the select pin altogether
    if (adaptor_s) begin
      ctl_d.charge_current = ac_code_q;
    end else if (current_select_pin_s) begin
      ctl_d.charge_current = LCS_CODE_100MA;
    end else begin
      ctl_d.charge_current = usb_code_q;
    end
    ctl_d.charge_on = (phase_q == LCS_PREQUAL) || (phase_q == LCS_CC) ||
                      (phase_q == LCS_CV);
    ctl_d.prequal   = (phase_q == LCS_PREQUAL);
    ctl_d.cv_mode   = (phase_q == LCS_CV);
    ctl_d.ldo_mode  = (phase_q == LCS_LDO);
    chg_ind_d = 1'b0;
    eoc_ind_d = 1'b0;
    // Indicators follow the phase; history picks red or green while charging
    case (phase_q)
      LCS_PREQUAL, LCS_CC, LCS_CV: begin
        chg_ind_d = !maint_seen_q;
        eoc_ind_d = maint_seen_q;
      end
      LCS_MAINT, LCS_DISABLED: eoc_ind_d = 1'b1;
      LCS_FAULT: begin
        chg_ind_d = 1'b1;
        eoc_ind_d = 1'b1;
      end
      default: begin
        chg_ind_d = 1'b0;
        eoc_ind_d = 1'b0;
      end
    endcase
  end

  // Register outputs
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_o                <= '0;
      charging_indicator_o <= 1'b0;
      eoc_indicator_o      <= 1'b0;
    end else begin
      ctl_o                <= ctl_d;
      charging_indicator_o <= chg_ind_d;
      eoc_indicator_o      <= eoc_ind_d;
    end
  end

  // Bus answers
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule
`default_nettype wire

// ### lcs_top_props.sv
// Port checker of the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module lcs_top_props
  import lcs_pkg::*;
#(
  parameter int PRESCALE      = LCS_PRESCALE,
  parameter int TIMEOUT_TICKS = LCS_TIMEOUT_TICKS
) (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire lcs_cmp_s    cmp_i,
  input wire logic        enable_pin_i,
  input wire logic        source_mode_pin_i,
  input wire logic        current_select_pin_i,
  input wire lcs_ctl_s    ctl_o,
  input wire logic        charging_indicator_o,
  input wire logic        eoc_indicator_o
);
  logic sup;  // Supply inside limits with adaptor good
  assign sup = cmp_i.supply_above_uv & cmp_i.supply_below_ov & cmp_i.adaptor_ok;
  longint cc_run_q;  // Consecutive cycles with constant-current controls
  // Count how long the controls stay in constant current
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cc_run_q <= 0;
    end else if (ctl_o.charge_on && !ctl_o.prequal && !ctl_o.cv_mode) begin
      cc_run_q <= cc_run_q + 1;
    end else begin
      cc_run_q <= 0;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  AST_ACK_ONCE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_ACK_NEXT:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  AST_FAULT_OFF:
    assert property (charging_indicator_o && eoc_indicator_o |-> !ctl_o.charge_on)
      else $error("charging during fault");
  AST_LDO_DARK:
    assert property (ctl_o.ldo_mode |-> !charging_indicator_o && !eoc_indicator_o)
      else $error("indicator lit in LDO");
  AST_USB_LOW:
    assert property ((!source_mode_pin_i && current_select_pin_i)[*6]
      |-> !ctl_o.charge_on || ctl_o.charge_current == LCS_CODE_100MA)
      else $error("USB low power current wrong");
  AST_NO_SUPPLY:
    assert property ((!sup)[*8] |-> !ctl_o.charge_on && !ctl_o.ldo_mode)
      else $error("active without supply");
  AST_EN_LOW:
    assert property ((sup && !enable_pin_i)[*8] |-> eoc_indicator_o && !charging_indicator_o
      && !ctl_o.charge_on && !ctl_o.ldo_mode) else $error("disable not honoured");
  AST_TEMP_OFF:
    assert property ((!cmp_i.ts_gt_1v39 || (cmp_i.ts_ge_2v427 && !cmp_i.ts_ge_2v7))[*8]
      |-> !ctl_o.charge_on) else $error("charging out of range");
  AST_LDO_SEL:
    assert property ((sup && enable_pin_i && cmp_i.ts_ge_2v7)[*8] |-> ctl_o.ldo_mode)
      else $error("LDO not selected");
  AST_CC_LIMIT:
    assert property (cc_run_q <= longint'(PRESCALE) * TIMEOUT_TICKS + 1)
      else $error("safety timer overrun");
  COV_CV: cover property ($rose(ctl_o.cv_mode));
  COV_LDO: cover property ($rose(ctl_o.ldo_mode));
  COV_FAULT: cover property (charging_indicator_o && eoc_indicator_o);
endmodule
bind lcs_top lcs_top_props #(.PRESCALE(PRESCALE), .TIMEOUT_TICKS(TIMEOUT_TICKS)) lcs_top_props_i (
  .clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_i(cmp_i), .enable_pin_i(enable_pin_i),
  .source_mode_pin_i(source_mode_pin_i), .current_select_pin_i(current_select_pin_i),
  .ctl_o(ctl_o), .charging_indicator_o(charging_indicator_o),
  .eoc_indicator_o(eoc_indicator_o));
`default_nettype wire

// ### test_lcs_top.sv
// Testbench of the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module test_lcs_top;
  import lcs_pkg::*;
  logic        clock_i, reset_i, cyc, stb, we, ack, smode, current_select_pin, en, sup, drain, hold;
  logic        charging_indicator, eoc;  // Indicator outputs
  logic [7:0]  adr;       // Bus address
  logic [31:0] dat, rdat; // Bus write and read data
  logic [1:0]  temp;      // Thermistor class fed to the model
  lcs_cmp_s    cmp;       // Model comparator flags
  lcs_ctl_s    ctl;       // Regulation controls
  int          fails, tests_run;
  lcs_top #(.PRESCALE(4), .TIMEOUT_TICKS(100)) lcs_top_i (.clock_i(clock_i), .reset_i(reset_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .cmp_i(cmp), .enable_pin_i(en),
    .source_mode_pin_i(smode), .current_select_pin_i(current_select_pin), .ctl_o(ctl),
    .charging_indicator_o(charging_indicator), .eoc_indicator_o(eoc));
  lcs_pack_model lcs_pack_model_i (.clock_i(clock_i), .reset_i(reset_i), .ctl_i(ctl),
    .supply_i(sup), .temp_i(temp), .drain_i(drain), .hold_i(hold), .cmp_o(cmp));
  // Verdict and end of run
  task automatic print_verdict();
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask
  // One classic bus cycle, waiting for ack under a bound
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, '0, r);
    chk(r, e);
  endtask
  // Poll the phase field until it shows p
  task automatic wait_ph(input logic [2:0] p);
    logic [31:0] r;
    for (int k = 0; k < 400; k++) begin
      bus(1'b0, LCS_REG_STAT, '0, r);
      if (r[2:0] === p) return;
    end
    fails++;
    print_verdict();
  endtask
  // Outputs {charge_on, prequal, cv, ldo, chg, eoc} once settled
  task automatic ost(input logic [5:0] m, input logic [5:0] e);
    repeat (2) @(negedge clock_i);
    chk({ctl.charge_on, ctl.prequal, ctl.cv_mode, ctl.ldo_mode, charging_indicator, eoc} & m, e);
    @(posedge clock_i);
  endtask
  task automatic pins(input logic s, input logic i, input logic [3:0] e);
    @(posedge clock_i);
    smode <= s;
    current_select_pin  <= i;
    repeat (8) @(posedge clock_i);
    chk(ctl.charge_current, e);
  endtask
  // Reset values, read-only bits, clamping, unmapped place
  task automatic t_regs();
    rdc(LCS_REG_CHG1, 32'h08);
    rdc(LCS_REG_CHG2, 32'h02);
    rdc(LCS_REG_CHG3, 32'h08);
    wr(LCS_REG_CHG2, 32'h1e);
    rdc(LCS_REG_CHG2, 32'h06);
    wr(LCS_REG_CHG1, 32'h1f);
    rdc(LCS_REG_CHG1, 32'h1d);
    wr(8'h10, 32'hff);
    rdc(8'h10, 32'h00);
  endtask
  // Full cycle, then recharges under end-of-charge selects 1 to 3
  task automatic t_cycle();
    @(posedge clock_i);
    sup <= 1'b1;
    wait_ph(3'h1);
    ost(6'h3f, 6'h32);
    wait_ph(3'h2);
    ost(6'h3f, 6'h22);
    wait_ph(3'h3);
    ost(6'h3f, 6'h2a);
    chk(ctl.vsel_4v2, 1'b1);
    wait_ph(3'h4);
    ost(6'h3f, 6'h01);
    for (int s = 1; s < 4; s++) begin
      wr(LCS_REG_CHG2, 32'(s << 1));
      rdc(LCS_REG_CHG2, 32'h10 | 32'(s << 1));
      @(posedge clock_i);
      drain <= 1'b1;
      @(posedge clock_i);
      drain <= 1'b0;
      wait_ph(3'h2);
      ost(6'h3f, 6'h21);
      wait_ph(3'h4);
    end
  endtask
  // Timer expiry, temperature fault and timer restart, current selection
  task automatic t_fault();
    @(posedge clock_i);
    sup   <= 1'b0;
    drain <= 1'b1;
    repeat (4) @(posedge clock_i);
    drain <= 1'b0;
    sup   <= 1'b1;
    wait_ph(3'h2);
    hold <= 1'b1;
    repeat (300) @(posedge clock_i);
    temp <= 2'h0;
    wait_ph(3'h5);
    ost(6'h3f, 6'h03);
    temp <= 2'h1;
    wait_ph(3'h2);
    pins(1'b1, 1'b1, 4'hd);
    pins(1'b0, 1'b1, LCS_CODE_100MA);
    pins(1'b0, 1'b0, LCS_RST_USB_CODE);
    pins(1'b1, 1'b1, 4'hd);
    repeat (250) @(posedge clock_i);
    rdc(LCS_REG_STAT, 32'h6a);
    wait_ph(3'h5);
    ost(6'h3f, 6'h03);
    repeat (20) @(posedge clock_i);
    rdc(LCS_REG_STAT, 32'h6d);
    hold <= 1'b0;
  endtask
  // LDO, disable and charger-off sense classes
  task automatic t_ldo();
    temp <= 2'h2;
    wait_ph(3'h6);
    ost(6'h1f, 6'h04);
    en <= 1'b0;
    wait_ph(3'h7);
    ost(6'h3f, 6'h01);
    en   <= 1'b1;
    temp <= 2'h3;
    wait_ph(3'h0);
    ost(6'h3f, 6'h00);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    {cyc, stb, we, adr, dat, drain, hold, sup} = '0;
    {smode, current_select_pin, en, reset_i} = 4'hf;
    temp = 2'h1;
    fails = 0;
    tests_run = 0;
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    t_regs();
    t_cycle();
    t_fault();
    t_ldo();
    print_verdict();
  end
endmodule
`default_nettype wire
